// File: hdl/touch_key_detect.sv
// Touch key detection: charge sequencer, frequency counting control and register port.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module touch_key_detect
	import touch_key_pkg::*;
#(
	parameter int FLAG_HOLD_NS = 43000, // Flag lifetime before the automatic clear.
	parameter int PERIOD_SHORT = PERIOD_SHORT_US, // Short counting period in microseconds.
	parameter int PERIOD_LONG = PERIOD_LONG_US // Long counting period in microseconds.
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Register port.
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// Data and state from the converter core.
	input wire logic [15:0] conv_inj_data,
	input wire logic [15:0] conv_reg_data,
	input wire logic [4:0] conv_channel,
	input wire logic adc_half_tick,
	// Pulse source of the frequency variant.
	input wire logic count_pulse_source,
	// Converter register writes that the touch unit does not take.
	output logic conv_wr,
	output logic [7:0] conv_wr_addr,
	output logic [31:0] conv_wr_data,
	// Analog front end control.
	output logic discharge_on,
	output logic charge_on,
	output logic convert_on,
	output logic charge_done,
	output logic [8:0] sample_half,
	output logic [4:0] mux_channel,
	// Converter interrupt request.
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Derived constants.
	localparam int FLAG_HOLD_RAW = FLAG_HOLD_NS / CLK_PERIOD_NS; // Longest time rounds down.
	localparam int FLAG_HOLD_CYC = (FLAG_HOLD_RAW < 1) ? 1 : FLAG_HOLD_RAW; // At least one cycle.
	localparam logic [15:0] FLAG_HOLD_LAST = 16'(FLAG_HOLD_CYC - 1); // Last cycle of the hold.

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Registers and internal signals.
	logic [2:0] count_clock_sel_r; // Bus clock base of the period timer.
	logic count_period_sel_r; // One for the long period.
	logic count_done_irq_en_r; // Interrupt enable of the done flag.
	logic touch_unit_en_r; // Touch unit enable.
	logic variant_r; // One picks the charge variant.
	logic count_done_flag_r; // Count done flag.
	logic [15:0] hold_cnt_r; // Age of the done flag in bus clocks.
	logic [29:0] chg_lo_r; // Charge selectors of channels 0 to 9.
	logic [23:0] chg_hi_r; // Charge selectors of channels 10 to 17.
	logic [4:0] count_channel_sel_r; // Channel of the frequency variant.
	logic [7:0] discharge_count_r; // Common discharge count.
	logic [13:0] count_value_r; // Last published count.
	logic count_valid_r; // The published count is valid.
	chg_state_t state_r; // Charge sequencer state.
	chg_state_t state_nxt; // Next charge sequencer state.
	logic [8:0] cnt_r; // Remaining cycles of the current phase.
	logic [8:0] cnt_nxt; // Next phase counter.
	logic charge_active; // Charge variant owns the aliased offsets.
	logic freq_active; // Frequency variant is running.
	logic wr_ctrl; // Write to the control register.
	logic wr_chan; // Write to the channel register.
	logic start_trigger; // Start of one charge detection.
	logic flag_set; // Hardware sets the done flag.
	logic flag_clr; // Software clears the done flag.
	logic flag_age_out; // The done flag reached its lifetime.
	logic count_done_flag_nxt; // Next done flag.
	logic [4:0] active_channel; // Channel in front of the converter.
	logic [2:0] active_sel; // Selector of the active channel.
	logic [19:0] period_len; // Period length in bus clocks.
	logic [31:0] period_us; // Period length in microseconds.
	logic fc_done; // Counter finished a period.
	logic [13:0] fc_count; // Count of the finished period.
	logic fc_overflow; // Count of the finished period saturated.

	// Selector of one channel out of the two selector registers.
	function automatic logic [2:0] chan_sel(input logic [29:0] lo, input logic [23:0] hi, input logic [4:0] ch);
		logic [4:0] idx;
		idx = ch - 5'(CHG_LO_CHANNELS);
		if (ch < 5'(CHG_LO_CHANNELS)) begin
			chan_sel = lo[ch*3 +: 3];
		end else if (idx < 5'h08) begin
			chan_sel = hi[idx*3 +: 3];
		end else begin
			chan_sel = 3'h0;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Decode of writes and variant ownership.
	assign charge_active = touch_unit_en_r & variant_r;
	assign freq_active = touch_unit_en_r & ~variant_r;
	assign wr_ctrl = wr_en & (addr == CTRL_OFF);
	assign wr_chan = wr_en & (addr == CHAN_OFF);
	assign start_trigger = wr_en & (addr == DATA_OFF) & charge_active;
	assign active_channel = variant_r ? conv_channel : count_channel_sel_r;
	assign active_sel = chan_sel(chg_lo_r, chg_hi_r, active_channel);

	// Period in bus clocks is the selected rate times the selected time.
	assign period_us = count_period_sel_r ? 32'(PERIOD_LONG) : 32'(PERIOD_SHORT);
	assign period_len = 20'(32'(clk_sel_mhz(count_clock_sel_r)) * period_us);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Control register fields; the flag is handled on its own below.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_clock_sel_r <= COUNT_CLOCK_SEL_RESET;
			count_period_sel_r <= REG_RESET[PSEL_BIT];
			count_done_irq_en_r <= REG_RESET[IEN_BIT];
			touch_unit_en_r <= REG_RESET[EN_BIT];
			variant_r <= REG_RESET[VARIANT_BIT];
		end else if (wr_ctrl) begin
			// Only defined fields are stored; the rest of the word is dropped.
			count_clock_sel_r <= wr_data[COUNT_CLOCK_SEL_LSB +: 3];
			count_period_sel_r <= wr_data[PSEL_BIT];
			count_done_irq_en_r <= wr_data[IEN_BIT];
			touch_unit_en_r <= wr_data[EN_BIT];
			variant_r <= wr_data[VARIANT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Configuration registers: selectors, channel and discharge count.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			chg_lo_r <= REG_RESET[29:0];
			chg_hi_r <= REG_RESET[23:0];
			count_channel_sel_r <= REG_RESET[4:0];
			discharge_count_r <= REG_RESET[7:0];
		end else if (wr_en) begin
			if (addr == CHG_LO_OFF) begin
				chg_lo_r <= wr_data[29:0] & CHG_LO_MASK;
			end
			if (addr == CHG_HI_OFF) begin
				chg_hi_r <= wr_data[23:0] & CHG_HI_MASK;
			end
			if (addr == CHAN_OFF) begin
				count_channel_sel_r <= wr_data[4:0];
			end
			// The discharge count is only taken while the charge variant owns the address.
			if (addr == DISCH_OFF && charge_active) begin
				discharge_count_r <= wr_data[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Writes to the aliased offsets go on to the converter only while the touch unit is disabled.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			conv_wr <= 1'b0;
			conv_wr_addr <= 8'h00;
			conv_wr_data <= 32'h00000000;
		end else begin
			conv_wr <= wr_en & ~touch_unit_en_r & ((addr == DISCH_OFF) | (addr == DATA_OFF));
			if (wr_en) begin
				conv_wr_addr <= addr;
				conv_wr_data <= wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Charge sequencer: discharge in bus clocks, then charge and convert in converter half clocks.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_IDLE: begin
				// A trigger while busy is ignored; the running detection completes.
				if (start_trigger) begin
					state_nxt = ST_DISCH;
					cnt_nxt = {1'b0, discharge_count_r};
				end
			end
			ST_DISCH: begin
				// Discharge lasts the count plus one bus clocks.
				if (cnt_r == 9'h000) begin
					state_nxt = ST_CHARGE;
					cnt_nxt = charge_half(active_sel) - 9'h001;
				end else begin
					cnt_nxt = cnt_r - 9'h001;
				end
			end
			ST_CHARGE: begin
				if (adc_half_tick) begin
					if (cnt_r == 9'h000) begin
						state_nxt = ST_CONV;
						cnt_nxt = 9'(CONV_HALF_TICKS - 1);
					end else begin
						cnt_nxt = cnt_r - 9'h001;
					end
				end
			end
			ST_CONV: begin
				if (adc_half_tick) begin
					if (cnt_r == 9'h000) begin
						state_nxt = ST_IDLE;
					end else begin
						cnt_nxt = cnt_r - 9'h001;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt = 9'h000;
			end
		endcase
		// Leaving the charge variant drops a detection under way.
		if (!charge_active) begin
			state_nxt = ST_IDLE;
			cnt_nxt = 9'h000;
		end
	end

	// Sequencer state and the phase outputs that follow it.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 9'h000;
			discharge_on <= 1'b0;
			charge_on <= 1'b0;
			convert_on <= 1'b0;
			charge_done <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			discharge_on <= (state_nxt == ST_DISCH);
			charge_on <= (state_nxt == ST_CHARGE);
			convert_on <= (state_nxt == ST_CONV);
			charge_done <= (state_r == ST_CONV) & (state_nxt == ST_IDLE) & charge_active;
		end
	end

	// Channel and sample time presented to the converter in every mode.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sample_half <= 9'h000;
			mux_channel <= 5'h00;
		end else begin
			sample_half <= charge_half(active_sel);
			mux_channel <= active_channel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Frequency variant counter; it runs whenever that variant is enabled.
	touch_freq_counter u_freq_counter (
		.clock(clock),
		.rst_n(rst_n),
		.run(freq_active),
		.restart(wr_chan),
		.period_len(period_len),
		.pulse(count_pulse_source),
		.done_r(fc_done),
		.count_r(fc_count),
		.overflow_r(fc_overflow)
	);

	// Published count and its validity; a channel change or a stop voids the old value.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_value_r <= 14'h0000;
			count_valid_r <= 1'b0;
		end else if (fc_done && freq_active && !wr_chan) begin
			count_value_r <= fc_count;
			count_valid_r <= ~fc_overflow;
		end else if (wr_chan || !freq_active) begin
			count_valid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Done flag: a set in the same cycle as a clear wins, so no completion is lost.
	assign flag_set = fc_done & freq_active & ~wr_chan;
	assign flag_clr = wr_ctrl & wr_data[FLAG_BIT];
	assign flag_age_out = count_done_flag_r & (hold_cnt_r == FLAG_HOLD_LAST);
	assign count_done_flag_nxt = flag_set | (count_done_flag_r & ~flag_clr & ~flag_age_out);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_done_flag_r <= REG_RESET[FLAG_BIT];
			hold_cnt_r <= 16'h0000;
			irq <= 1'b0;
		end else begin
			count_done_flag_r <= count_done_flag_nxt;
			// The age counter restarts on every set.
			if (flag_set || !count_done_flag_r) begin
				hold_cnt_r <= 16'h0000;
			end else begin
				hold_cnt_r <= hold_cnt_r + 16'h0001;
			end
			irq <= count_done_flag_nxt & count_done_irq_en_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Read data stand in the cycle after the strobe only; unmapped offsets read zero.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_data <= 32'h00000000;
		end else if (rd_en) begin
			case (addr)
				CTRL_OFF: begin
					rd_data <= {1'b0, count_clock_sel_r, count_done_flag_r, count_period_sel_r,
						count_done_irq_en_r, touch_unit_en_r, variant_r, 23'h000000};
				end
				CHG_HI_OFF: begin
					rd_data <= {8'h00, chg_hi_r};
				end
				CHG_LO_OFF: begin
					rd_data <= {2'h0, chg_lo_r};
				end
				CHAN_OFF: begin
					rd_data <= {27'h0000000, count_channel_sel_r};
				end
				DISCH_OFF: begin
					// The discharge count is write only; reads show the injected data.
					rd_data <= {16'h0000, conv_inj_data};
				end
				DATA_OFF: begin
					if (freq_active) begin
						rd_data <= {16'h0000, count_valid_r, 1'b0, count_value_r};
					end else begin
						rd_data <= {16'h0000, conv_reg_data};
					end
				end
				default: begin
					rd_data <= 32'h00000000;
				end
			endcase
		end else begin
			rd_data <= 32'h00000000;
		end
	end

endmodule

// File: hdl/touch_key_pkg.sv
// Package with register map, field layout, reset values and timing constants of the touch key block.
package touch_key_pkg;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the register port.
	localparam logic [7:0] CTRL_OFF = 8'h04; // Control: clock base, flag, period, irq enable, enables.
	localparam logic [7:0] CHG_HI_OFF = 8'h0C; // Charge time selectors of channels 10 to 17.
	localparam logic [7:0] CHG_LO_OFF = 8'h10; // Charge time selectors of channels 0 to 9.
	localparam logic [7:0] CHAN_OFF = 8'h34; // Count channel selection.
	localparam logic [7:0] DISCH_OFF = 8'h3C; // Discharge count on write, injected data on read.
	localparam logic [7:0] DATA_OFF = 8'h4C; // Start trigger on write, result or status on read.

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Control register field positions.
	localparam int COUNT_CLOCK_SEL_LSB = 28; // Count clock selection, three bits.
	localparam int FLAG_BIT = 27; // Count done flag, write one to clear.
	localparam int PSEL_BIT = 26; // Count period selection.
	localparam int IEN_BIT = 25; // Count done interrupt enable.
	localparam int EN_BIT = 24; // Touch unit enable.
	localparam int VARIANT_BIT = 23; // One selects the charge variant, zero the frequency variant.

	// Field widths and masks of the other registers.
	localparam logic [29:0] CHG_LO_MASK = 30'h3FFFFFFF; // Ten channels of three bits.
	localparam logic [23:0] CHG_HI_MASK = 24'hFFFFFF; // Eight channels of three bits.
	localparam int CHG_LO_CHANNELS = 10; // Channels held in the low selector register.

	// Reset values.
	localparam logic [31:0] REG_RESET = 32'h00000000; // All touch registers reset to zero.
	localparam logic [2:0] COUNT_CLOCK_SEL_RESET = 3'h0; // Count clock base resets to the lowest rate.

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Timing constants.
	localparam int CLK_PERIOD_NS = 8; // Bus clock period at 125 MHz.
	localparam int CONV_HALF_TICKS = 27; // The 13.5 converter clock conversion in half clocks.
	localparam int PERIOD_SHORT_US = 500; // Short counting period.
	localparam int PERIOD_LONG_US = 1000; // Long counting period.

	// Sequencer state of the charge variant.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DISCH = 2'b01,
		ST_CHARGE = 2'b10,
		ST_CONV = 2'b11
	} chg_state_t;

	// Charge or sample time in converter half clocks for a three bit selector.
	function automatic logic [8:0] charge_half(input logic [2:0] sel);
		case (sel)
			3'h0: charge_half = 9'h003;
			3'h1: charge_half = 9'h00F;
			3'h2: charge_half = 9'h01B;
			3'h3: charge_half = 9'h039;
			3'h4: charge_half = 9'h053;
			3'h5: charge_half = 9'h06F;
			3'h6: charge_half = 9'h08F;
			default: charge_half = 9'h1DF;
		endcase
	endfunction

	// Bus clock frequency in MHz named by the count clock selection.
	function automatic logic [5:0] clk_sel_mhz(input logic [2:0] sel);
		case (sel)
			3'h0: clk_sel_mhz = 6'h08;
			3'h1: clk_sel_mhz = 6'h0C;
			3'h2: clk_sel_mhz = 6'h18;
			3'h3: clk_sel_mhz = 6'h24;
			3'h4: clk_sel_mhz = 6'h30;
			3'h5: clk_sel_mhz = 6'h38;
			default: clk_sel_mhz = 6'h08;
		endcase
	endfunction

endpackage

// File: hdl/touch_freq_counter.sv
// Period timer and pulse counter of the frequency sensing variant.
`timescale 1ns/1ps
module touch_freq_counter (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Control.
	input wire logic run,
	input wire logic restart,
	input wire logic [19:0] period_len,
	// Pulse source to be counted.
	input wire logic pulse,
	// Result.
	output logic done_r,
	output logic [13:0] count_r,
	output logic overflow_r
);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	logic pulse_d_r; // Previous pulse level for edge detection.
	logic [19:0] timer_r; // Bus clocks elapsed in the current period.
	logic [13:0] acc_r; // Pulse edges counted in the current period.
	logic acc_ovf_r; // The accumulator saturated in the current period.
	logic edge_seen; // A rising pulse edge in this cycle.
	logic period_end; // Last bus clock of the period.
	logic [13:0] acc_nxt; // Accumulator including this cycle's edge.
	logic ovf_nxt; // Overflow including this cycle's edge.

	assign edge_seen = pulse & ~pulse_d_r;
	assign period_end = (timer_r == period_len - 20'h00001);
	assign acc_nxt = (edge_seen && acc_r != 14'h3FFF) ? acc_r + 14'h0001 : acc_r;
	assign ovf_nxt = acc_ovf_r | (edge_seen & (acc_r == 14'h3FFF));

	// Edge detector register.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pulse_d_r <= 1'b0;
		end else begin
			pulse_d_r <= pulse;
		end
	end

	// Counting runs back to back; a restart or a stop drops the period under way.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timer_r <= 20'h00000;
			acc_r <= 14'h0000;
			acc_ovf_r <= 1'b0;
		end else if (!run || restart) begin
			timer_r <= 20'h00000;
			acc_r <= 14'h0000;
			acc_ovf_r <= 1'b0;
		end else if (period_end) begin
			timer_r <= 20'h00000;
			acc_r <= 14'h0000;
			acc_ovf_r <= 1'b0;
		end else begin
			timer_r <= timer_r + 20'h00001;
			acc_r <= acc_nxt;
			acc_ovf_r <= ovf_nxt;
		end
	end

	// Result capture at the end of each full period.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done_r <= 1'b0;
			count_r <= 14'h0000;
			overflow_r <= 1'b0;
		end else begin
			done_r <= run & ~restart & period_end;
			if (run && !restart && period_end) begin
				count_r <= acc_nxt;
				overflow_r <= ovf_nxt;
			end
		end
	end

endmodule

// File: testbench/touch_key_detect_assertions.sv
// Checker of the touch key block's port behaviour.
`timescale 1ns/1ps
module touch_key_detect_checker
	import touch_key_pkg::*;
(
	// Ports watched.
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	input wire logic [15:0] conv_inj_data,
	input wire logic [15:0] conv_reg_data,
	input wire logic adc_half_tick,
	input wire logic conv_wr,
	input wire logic [7:0] conv_wr_addr,
	input wire logic discharge_on,
	input wire logic charge_on,
	input wire logic convert_on,
	input wire logic charge_done,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [1:0] mode_r; // Enable and variant bits as last written.
	logic ien_r; // Interrupt enable as last written.
	logic [7:0] disch_r; // Discharge count as last accepted.
	logic [8:0] dcnt_r; // Cycles of the running discharge.
	logic [5:0] tcnt_r; // Half ticks of the running conversion.
	wire busy = discharge_on | charge_on | convert_on;
	////////////////////////////////////////////////////////////////////////////////
	// Mirror of the control fields and the discharge count that the properties depend on.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_r <= 2'h0;
			ien_r <= 1'b0;
			disch_r <= 8'h00;
		end else if (wr_en && addr == CTRL_OFF) begin
			mode_r <= {wr_data[EN_BIT], wr_data[VARIANT_BIT]};
			ien_r <= wr_data[IEN_BIT];
		end else if (wr_en && addr == DISCH_OFF && mode_r == 2'h3) begin
			disch_r <= wr_data[7:0];
		end
	end
	// Phase length counters, cleared whenever their phase is idle.
	always_ff @(posedge clock) begin
		if (!rst_n || !discharge_on) begin
			dcnt_r <= 9'h000;
		end else begin
			dcnt_r <= dcnt_r + 9'h001;
		end
		if (!rst_n || !convert_on) begin
			tcnt_r <= 6'h00;
		end else if (adc_half_tick) begin
			tcnt_r <= tcnt_r + 6'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_inj_read: assert property (rd_en && addr == DISCH_OFF |=> rd_data == {16'h0000, $past(conv_inj_data)})
		else $error("injected data read wrong");
	a_result_read: assert property (rd_en && addr == DATA_OFF && mode_r != 2'h2
		|=> rd_data == {16'h0000, $past(conv_reg_data)}) else $error("converted data read wrong");
	a_start_disch: assert property (wr_en && addr == DATA_OFF && mode_r == 2'h3 && !busy |=> discharge_on)
		else $error("trigger did not start discharge");
	a_disch_len: assert property ($fell(discharge_on) && $past(rst_n) |-> dcnt_r == disch_r + 9'h001 && charge_on)
		else $error("discharge length wrong");
	a_phase_excl: assert property ($onehot0({discharge_on, charge_on, convert_on}))
		else $error("phases overlap");
	a_conv_ticks: assert property (charge_done |-> !convert_on && tcnt_r == 6'h1B)
		else $error("conversion length wrong");
	a_irq_gate: assert property (irq |-> ien_r || $past(ien_r))
		else $error("interrupt while disabled");
	a_fwd_write: assert property (wr_en && (addr == DISCH_OFF || addr == DATA_OFF) && !mode_r[1]
		|=> conv_wr && conv_wr_addr == $past(addr)) else $error("write not forwarded");
	a_no_fwd: assert property (wr_en && addr == DATA_OFF && mode_r[1] |=> !conv_wr)
		else $error("write forwarded while enabled");
endmodule
bind touch_key_detect touch_key_detect_checker u_touch_key_detect_checker (.clock, .rst_n, .addr, .wr_data,
	.wr_en, .rd_en, .rd_data, .conv_inj_data, .conv_reg_data, .adc_half_tick, .conv_wr, .conv_wr_addr,
	.discharge_on, .charge_on, .convert_on, .charge_done, .irq);

// File: testbench/touch_pad_model.sv
// Behavioural touch pad oscillator feeding the pulse counter.
`timescale 1ns/1ps
module touch_pad_model #(
	parameter int HALF = 2 // Clocks per half period of the pad oscillator.
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Oscillator output.
	output logic pad_osc
);
	int cnt; // Clocks since the last toggle.
	// The pad oscillates freely; its rate stands for the pad capacitance.
	always_ff @(posedge clock) begin
		if (!rst_n || cnt == HALF - 1) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
		if (!rst_n) begin
			pad_osc <= 1'b0;
		end else if (cnt == HALF - 1) begin
			pad_osc <= !pad_osc;
		end
	end
endmodule

// File: testbench/touch_key_detect_tb.sv
// Self-checking bench of the touch key block.
`timescale 1ns/1ps
module touch_key_detect_tb;
	import touch_key_pkg::*;
	localparam int HOLD = 400 / 8; // Flag lifetime in clocks.
	localparam logic [8:0] HTAB [8] = '{9'h003, 9'h00F, 9'h01B, 9'h039, 9'h053, 9'h06F, 9'h08F, 9'h1DF};
	localparam int MHZ [8] = '{8, 12, 24, 36, 48, 56, 8, 8}; // Reserved codes act as the lowest rate.
	logic clock = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, tick = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0, rd_data, q, w, fwd_d;
	logic [15:0] inj = 16'h0, regd = 16'h0;
	logic [4:0] chan = 5'h0, mux;
	logic [8:0] half;
	logic pad, irq, dis, chg, cnv, done;
	int fails = 0, n_checks = 0, cyc = 0, n, t, c, p, len;
	always #4 clock = !clock;
	// Converter half clock at half the bus rate.
	always @(posedge clock) tick <= !tick;
	touch_key_detect #(.FLAG_HOLD_NS(400), .PERIOD_SHORT(1), .PERIOD_LONG(2)) u_touch_key_detect (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .conv_inj_data(inj), .conv_reg_data(regd), .conv_channel(chan), .adc_half_tick(tick),
		.count_pulse_source(pad), .conv_wr(), .conv_wr_addr(), .conv_wr_data(fwd_d), .discharge_on(dis),
		.charge_on(chg), .convert_on(cnv), .charge_done(done), .sample_half(half), .mux_channel(mux), .irq(irq));
	touch_pad_model u_touch_pad_model (.clock(clock), .rst_n(rst_n), .pad_osc(pad));
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One write cycle, then one idle cycle so strobes never collide.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		@(posedge clock);
	endtask
	// Read data are taken in the single cycle after the strobe.
	task automatic rd(input logic [7:0] a);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		q = rd_data;
		@(posedge clock);
	endtask
	// Irq is looked at on falling edges, where it has settled; the task returns on a rising edge.
	task automatic wait_irq(input int lim);
		t = 0;
		do begin
			@(negedge clock);
			t++;
		end while (irq !== 1'b1 && t < lim);
		@(posedge clock);
	endtask
	// Hang guard.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		n = $urandom(29);
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		inj <= 16'($urandom());
		regd <= 16'($urandom());
		rd(CHG_LO_OFF);
		chk(q, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20);
		chk(q, 32'h0);
		wr(CHG_HI_OFF, 32'hFFFFFFFF);
		rd(CHG_HI_OFF);
		chk(q, 32'h00FFFFFF);
		w = $urandom();
		wr(DATA_OFF, w);
		chk(fwd_d, w);
		rd(DISCH_OFF);
		chk(q, {16'h0, inj});
		rd(DATA_OFF);
		chk(q, {16'h0, regd});
		$display("test registers done");
		wr(CTRL_OFF, 32'h01800000);
		for (int s = 0; s < 8; s++) begin
			c = $urandom_range(9);
			chan <= c[4:0];
			w = $urandom_range(32'h3FFFFFFF);
			w[3*c+:3] = s[2:0];
			wr(CHG_LO_OFF, w);
			wr(DISCH_OFF, (s == 0) ? 32'h0 : $urandom_range(255));
			wr(DATA_OFF, 32'h0);
			n = 0;
			t = 0;
			while (done !== 1'b1 && t < 3000) begin
				@(negedge clock);
				t++;
				n += chg & tick;
			end
			@(posedge clock);
			chk(half, HTAB[s]);
			chk(mux, c);
			chk(n, HTAB[s]);
		end
		$display("test charge done");
		for (int s = 0; s < 8; s++) begin
			p = s % 2;
			len = MHZ[s] * (p + 1);
			wr(CTRL_OFF, 32'h08000000);
			wr(CTRL_OFF, {1'b0, 3'(s), 1'b1, 1'(p), 3'b110, 23'h0});
			wr(CHAN_OFF, $urandom_range(15));
			wait_irq(200);
			// The flag rises two registered cycles after the last clock of the period.
			chk(t, len + 1);
			rd(DATA_OFF);
			chk(q[31:14], 18'h00002);
			chk(q[13:0] + 1 >= len / 4 && q[13:0] <= len / 4 + 1, 1);
			wr(CTRL_OFF, {1'b0, 3'(s), 1'b1, 1'(p), 3'b110, 23'h0});
			@(negedge clock);
			chk(irq, 1'b0);
			@(posedge clock);
		end
		wr(CTRL_OFF, {1'b0, 3'h5, 1'b1, 1'b1, 3'b110, 23'h0});
		wait_irq(300);
		repeat (HOLD - 2) @(posedge clock);
		@(negedge clock);
		chk(irq, 1'b1);
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk(irq, 1'b0);
		wait_irq(120);
		@(negedge clock);
		chk(irq, 1'b1);
		$display("test frequency done");
		final_report();
	end
endmodule
